// [core/rcp_cell_memory.sv]
// cell payload store of the four-cell receive fifo
`timescale 1ns/1ns
`default_nettype none
module rcp_cell_memory
  import rcp_pkg::*;
(
  // clock
  input  wire logic       ref_clk,
  // write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // read side, data one cycle later
  input  wire logic       rd_en,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data
);
  logic [7:0] mem_q [RCP_MEM_WORDS];

  // storage with registered read port
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule
`default_nettype wire

// [core/rcp_receive_cell_processor.sv]
// receive cell processor: delineation, header check, filter, fifo and registers
`timescale 1ns/1ns
`default_nettype none
module rcp_receive_cell_processor
  import rcp_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // octet stream from the path
  input  wire logic [7:0] line_data,
  input  wire logic       line_valid,
  // fifo read side
  input  wire logic       receive_read_enable,
  output logic            receive_cell_available,
  output logic      [7:0] receive_data_out,
  output logic            receive_parity_out,
  output logic            receive_start_of_cell,
  output logic            receive_data_valid,
  // event request
  output logic            receive_irq
);
  logic [7:0]    ctrl_q, evt_q, evt_d, set_vec, pattern_q, mask_q, rdata_d;
  rcp_delin_type delin_q, delin_d;
  rcp_check_type check_q, check_d;
  logic [2:0]    cnt_q, cnt_d;
  logic [5:0]    idx_q, idx_d, rd_idx_q, pay_idx, rd_pay_idx;
  logic [31:0]   hist_q;
  logic [42:0]   dscr_q;
  logic [50:0]   dscr_res;
  logic [2:0]    wr_ptr_q, rd_ptr_q;
  logic          live_q, delin_evt;
  logic [7:0]    hdr_q [4][5];
  logic          s1_valid_q, s1_soc_q, s1_hdr_q;
  logic [7:0]    s1_byte_q, mem_rdata, out_byte, dout_d;
  logic [7:0]    syndrome, pay_byte;
  logic [39:0]   err_mask, hdr_fixed;
  logic          receive_fifo_clear, payload_descramble_disable, coset_add_enable;
  logic          header_error_cell_pass, header_correction_disable, filter_pass;
  logic          receive_parity_type, delineation_lost_status;
  logic          wr_ctrl, wr_evt, wr_pat, wr_mask, rd_evt;
  logic          hcs_good, hcs_byte, sync_hcs, correctable, idle_match, accept;
  logic          chcs_evt, uhcs_evt, overrun_evt, take, pay_step, pay_wr, pay_last;
  logic          fifo_empty, fifo_full, rd_go, rd_last;

  // control fields
  assign receive_fifo_clear         = ctrl_q[RCP_FIFO_CLR_BIT];
  assign payload_descramble_disable = ctrl_q[RCP_DSCR_DIS_BIT];
  assign coset_add_enable           = ctrl_q[RCP_COSET_BIT];
  assign header_error_cell_pass     = ctrl_q[RCP_HCS_PASS_BIT];
  assign header_correction_disable  = ctrl_q[RCP_CORR_DIS_BIT];
  assign filter_pass                = ctrl_q[RCP_FILT_PASS_BIT];
  assign receive_parity_type        = ctrl_q[RCP_PAR_TYPE_BIT];
  assign delineation_lost_status    = (delin_q != RCP_SYNC);

  // address decode
  assign wr_ctrl = reg_write && reg_addr == RCP_CTRL_ADDR;
  assign wr_evt  = reg_write && reg_addr == RCP_EVT_ADDR;
  assign wr_pat  = reg_write && reg_addr == RCP_PATTERN_ADDR;
  assign wr_mask = reg_write && reg_addr == RCP_MASK_ADDR;
  assign rd_evt  = reg_read && reg_addr == RCP_EVT_ADDR;

  // read data selection
  always_comb begin
    case (reg_addr)
      RCP_CTRL_ADDR:    rdata_d = {delineation_lost_status, ctrl_q[6:0]};
      RCP_EVT_ADDR:     rdata_d = evt_q;
      RCP_PATTERN_ADDR: rdata_d = pattern_q;
      RCP_MASK_ADDR:    rdata_d = mask_q;
      default:          rdata_d = 8'h00;
    endcase
  end

  // header check on the incoming octet
  assign syndrome  = rcp_crc8(hist_q) ^ line_data ^ (coset_add_enable ? RCP_COSET : 8'h00);
  assign hcs_good  = (syndrome == 8'h00);
  assign hcs_byte  = line_valid && delin_q != RCP_HUNT && idx_q == RCP_HCS_IDX;
  assign sync_hcs  = hcs_byte && delin_q == RCP_SYNC;
  assign err_mask  = rcp_err_mask(syndrome);
  assign correctable = !hcs_good && err_mask != 40'h0 && check_q == RCP_CORR
                       && !header_correction_disable;
  assign hdr_fixed = {hist_q, line_data} ^ (correctable ? err_mask : 40'h0);
  assign chcs_evt  = sync_hcs && correctable;
  assign uhcs_evt  = sync_hcs && !hcs_good && !correctable;

  // idle or unassigned cell filter
  assign idle_match = hdr_fixed[35:12] == 24'h0
                      && ((({hdr_fixed[39:36], hdr_fixed[11:8]} ^ pattern_q) & mask_q) == 8'h00);

  // cell acceptance
  assign accept = sync_hcs
                  && (hcs_good || correctable || header_error_cell_pass)
                  && !(idle_match && !filter_pass)
                  && !receive_fifo_clear;
  assign fifo_empty  = (wr_ptr_q == rd_ptr_q);
  assign fifo_full   = (wr_ptr_q ^ rd_ptr_q) == 3'h4;
  assign overrun_evt = accept && fifo_full;
  assign take        = accept && !fifo_full;

  // payload path
  assign pay_step = line_valid && delin_q != RCP_HUNT && idx_q >= RCP_HDR_BYTES;
  assign dscr_res = rcp_descramble(dscr_q, line_data);
  assign pay_byte = payload_descramble_disable ? line_data : dscr_res[7:0];
  assign pay_wr   = pay_step && live_q && !receive_fifo_clear;
  assign pay_last = pay_wr && idx_q == RCP_CELL_LAST;
  assign pay_idx  = idx_q - RCP_HDR_BYTES;

  // cell delineation machine
  always_comb begin
    delin_d   = delin_q;
    cnt_d     = cnt_q;
    idx_d     = idx_q;
    delin_evt = 1'b0;
    if (line_valid && delin_q != RCP_HUNT) begin
      idx_d = (idx_q == RCP_CELL_LAST) ? 6'h00 : idx_q + 6'h01;
    end
    unique case (delin_q)
      RCP_HUNT: begin
        if (line_valid && hcs_good) begin
          delin_d = RCP_PRESYNC;
          cnt_d   = 3'h0;
          idx_d   = RCP_HDR_BYTES;
        end
      end
      RCP_PRESYNC: begin
        if (hcs_byte && !hcs_good) begin
          delin_d = RCP_HUNT;
        end else if (hcs_byte && cnt_q == RCP_DELTA - 3'h1) begin
          delin_d   = RCP_SYNC;
          cnt_d     = 3'h0;
          delin_evt = 1'b1;
        end else if (hcs_byte) begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      RCP_SYNC: begin
        if (hcs_byte && hcs_good) begin
          cnt_d = 3'h0;
        end else if (hcs_byte && cnt_q == RCP_ALPHA - 3'h1) begin
          delin_d   = RCP_HUNT;
          delin_evt = 1'b1;
        end else if (hcs_byte) begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      default: begin
        delin_d = RCP_HUNT;
      end
    endcase
  end

  // header verification mode
  always_comb begin
    check_d = check_q;
    if (header_error_cell_pass) begin
      check_d = RCP_CORR;
    end else if (sync_hcs) begin
      check_d = hcs_good ? RCP_CORR : RCP_DET;
    end
  end

  // event flags: set wins over the read clear
  always_comb begin
    set_vec                 = 8'h00;
    set_vec[RCP_OVR_FLAG]   = overrun_evt;
    set_vec[RCP_UHCS_FLAG]  = uhcs_evt;
    set_vec[RCP_CHCS_FLAG]  = chcs_evt;
    set_vec[RCP_DELIN_FLAG] = delin_evt;
    evt_d = evt_q;
    if (wr_evt) begin
      evt_d = (evt_q & ~RCP_EVT_EMASK) | (reg_wdata & RCP_EVT_EMASK);
    end
    if (rd_evt) begin
      evt_d = evt_d & ~RCP_EVT_FMASK;
    end
    evt_d = evt_d | set_vec;
  end

  // gated request
  assign receive_irq = (evt_q[RCP_OVR_FLAG] && evt_q[RCP_OVR_EN])
                       || ((evt_q[RCP_UHCS_FLAG] || evt_q[RCP_CHCS_FLAG]) && evt_q[RCP_HCS_EN])
                       || (evt_q[RCP_DELIN_FLAG] && evt_q[RCP_DELIN_EN]);

  // register file
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q    <= RCP_CTRL_RESET;
      evt_q     <= RCP_EVT_RESET;
      pattern_q <= RCP_MATCH_RESET;
      mask_q    <= RCP_MATCH_RESET;
      reg_rdata <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata & RCP_CTRL_WMASK;
      end
      if (wr_pat) begin
        pattern_q <= reg_wdata;
      end
      if (wr_mask) begin
        mask_q <= reg_wdata;
      end
      evt_q     <= evt_d;
      reg_rdata <= reg_read ? rdata_d : 8'h00;
    end
  end

  // delineation, history and write-side state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      delin_q  <= RCP_HUNT;
      check_q  <= RCP_CORR;
      cnt_q    <= 3'h0;
      idx_q    <= 6'h00;
      hist_q   <= 32'h0;
      dscr_q   <= 43'h0;
      live_q   <= 1'b0;
      wr_ptr_q <= 3'h0;
    end else begin
      delin_q <= delin_d;
      check_q <= check_d;
      cnt_q   <= cnt_d;
      idx_q   <= idx_d;
      if (line_valid) begin
        hist_q <= {hist_q[23:0], line_data};
      end
      if (pay_step) begin
        dscr_q <= dscr_res[50:8];
      end
      if (receive_fifo_clear || delin_d == RCP_HUNT || pay_last) begin
        live_q <= 1'b0;
      end else if (take) begin
        live_q <= 1'b1;
      end
      if (receive_fifo_clear) begin
        wr_ptr_q <= 3'h0;
      end else if (pay_last) begin
        wr_ptr_q <= wr_ptr_q + 3'h1;
      end
    end
  end

  // header store of each fifo slot
  always_ff @(posedge ref_clk) begin
    if (take) begin
      for (int k = 0; k < 5; k++) begin
        hdr_q[wr_ptr_q[1:0]][k] <= hdr_fixed[8 * (4 - k) +: 8];
      end
    end
  end

  // read side
  assign receive_cell_available = !fifo_empty && !receive_fifo_clear;
  assign rd_go      = receive_read_enable && receive_cell_available;
  assign rd_last    = rd_idx_q == RCP_CELL_LAST;
  assign rd_pay_idx = rd_idx_q - RCP_HDR_BYTES;
  assign out_byte   = s1_hdr_q ? s1_byte_q : mem_rdata;
  assign dout_d     = s1_valid_q ? out_byte : 8'h00; // parity follows the driven octet

  rcp_cell_memory u_mem (
    .ref_clk (ref_clk),
    .wr_en   (pay_wr),
    .wr_addr ({wr_ptr_q[1:0], pay_idx}),
    .wr_data (pay_byte),
    .rd_en   (rd_go),
    .rd_addr ({rd_ptr_q[1:0], rd_pay_idx}),
    .rd_data (mem_rdata)
  );

  // read pointer and two-stage output pipeline
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ptr_q              <= 3'h0;
      rd_idx_q              <= 6'h00;
      s1_valid_q            <= 1'b0;
      s1_soc_q              <= 1'b0;
      s1_hdr_q              <= 1'b0;
      s1_byte_q             <= 8'h00;
      receive_data_out      <= 8'h00;
      receive_parity_out    <= 1'b0;
      receive_start_of_cell <= 1'b0;
      receive_data_valid    <= 1'b0;
    end else begin
      if (receive_fifo_clear) begin
        rd_ptr_q <= 3'h0;
        rd_idx_q <= 6'h00;
      end else if (rd_go) begin
        rd_idx_q <= rd_last ? 6'h00 : rd_idx_q + 6'h01;
        rd_ptr_q <= rd_last ? rd_ptr_q + 3'h1 : rd_ptr_q;
      end
      s1_valid_q <= rd_go;
      s1_soc_q   <= rd_go && rd_idx_q == 6'h00;
      s1_hdr_q   <= rd_idx_q < RCP_HDR_BYTES;
      s1_byte_q  <= (rd_idx_q < RCP_HDR_BYTES) ? hdr_q[rd_ptr_q[1:0]][rd_idx_q[2:0]] : 8'h00;
      receive_data_valid    <= s1_valid_q;
      receive_start_of_cell <= s1_soc_q;
      receive_data_out      <= dout_d;
      receive_parity_out    <= receive_parity_type ? ^dout_d : ~^dout_d;
    end
  end

  // checks
  default clocking dflt_cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_presync_done;
    delin_q == RCP_PRESYNC && hcs_byte && hcs_good && cnt_q == RCP_DELTA - 3'h1;
  endsequence
  sequence s_sync_flagged;
    delin_q == RCP_SYNC && evt_q[RCP_DELIN_FLAG];
  endsequence

  a_sync_entry_flag: assert property (s_presync_done |=> s_sync_flagged)
    else $error("delineation flag not set on sync entry");
  a_clear_empties: assert property (receive_fifo_clear |=> fifo_empty && !receive_cell_available)
    else $error("fifo not empty while clear is set");
  a_hunt_drop: assert property (delin_q != RCP_SYNC |-> !pay_wr && !live_q)
    else $error("cell taken outside sync");
  a_pass_corr_mode: assert property (header_error_cell_pass |=> check_q == RCP_CORR)
    else $error("checker left correction mode under pass");
  a_idle_drop: assert property (sync_hcs && idle_match && !filter_pass |=> !live_q)
    else $error("idle cell not dropped");
  a_overrun_latch: assert property (overrun_evt |=> evt_q[RCP_OVR_FLAG] [*2] or
                                    (evt_q[RCP_OVR_FLAG] ##1 $past(rd_evt)))
    else $error("overrun flag not latched");
  a_read_clears: assert property (rd_evt && !overrun_evt |=> !evt_q[RCP_OVR_FLAG])
    else $error("overrun flag survived status read");
  a_uncorr_flag: assert property (uhcs_evt |=> evt_q[RCP_UHCS_FLAG])
    else $error("uncorrectable flag not latched");
  a_lost_status: assert property (reg_read && reg_addr == RCP_CTRL_ADDR
                                  |=> reg_rdata[RCP_LOST_BIT] == ($past(delin_q) != RCP_SYNC))
    else $error("delineation status bit wrong");
  a_irq_gate: assert property (!evt_q[RCP_OVR_EN] && !evt_q[RCP_HCS_EN] && !evt_q[RCP_DELIN_EN]
                               |-> !receive_irq)
    else $error("request raised with all enables off");
  a_read_latency: assert property (rd_go ##1 1'b1 |=> receive_data_valid)
    else $error("read data not valid two cycles after strobe");
endmodule
`default_nettype wire

// [inc/rcp_pkg.sv]
// constants and helper functions of the receive cell processor
// Summary of operation
// - fifo clear bit set empties the four-cell fifo and drops writes until cleared
// - payload descrambled when descramble-disable is zero, passed raw when one
// - coset enable adds x^6+x^4+x^2+1 to the check octet before comparing
// - header-error pass zero drops uncorrectable cells, one writes them anyway
// - header-error pass one keeps the header checker in correction mode
// - all cells dropped while delineation is in hunt or presync
// - correction-disable zero corrects single-bit header errors while the checker is in correction mode
// - correction-disable one treats every header error as uncorrectable
// - filter pass zero drops cells matching the idle or unassigned filter
// - filter pass one disables the filter entirely
// - reset values drop cells whose vpi and vci are all zero
// - parity output is even parity when parity type is one, odd when zero
// - status bit reads one in hunt or presync, zero in sync
// - overrun flag latched, cleared by reading the event register
// - uncorrectable header flag latched, cleared by reading the event register
// - correctable header flag latched, cleared by reading the event register
// - delineation flag set on presync-to-sync and sync-to-hunt, cleared on read
// - overrun raises the request only with its enable set
// - header errors raise the request only with their enable set
// - delineation change raises the request only with its enable set
// - filter compares gfc, pti and clp bits whose mask bit is one
package rcp_pkg;
  // register map
  localparam logic [7:0] RCP_CTRL_ADDR    = 8'h50;
  localparam logic [7:0] RCP_EVT_ADDR     = 8'h51;
  localparam logic [7:0] RCP_PATTERN_ADDR = 8'h52;
  localparam logic [7:0] RCP_MASK_ADDR    = 8'h53;
  // control register fields
  localparam int RCP_FIFO_CLR_BIT  = 0;
  localparam int RCP_DSCR_DIS_BIT  = 1;
  localparam int RCP_COSET_BIT     = 2;
  localparam int RCP_HCS_PASS_BIT  = 3;
  localparam int RCP_CORR_DIS_BIT  = 4;
  localparam int RCP_FILT_PASS_BIT = 5;
  localparam int RCP_PAR_TYPE_BIT  = 6;
  localparam int RCP_LOST_BIT      = 7;
  localparam logic [7:0] RCP_CTRL_RESET = 8'h04;
  localparam logic [7:0] RCP_CTRL_WMASK = 8'h7f;
  // event register fields
  localparam int RCP_OVR_FLAG   = 1;
  localparam int RCP_UHCS_FLAG  = 2;
  localparam int RCP_CHCS_FLAG  = 3;
  localparam int RCP_DELIN_FLAG = 4;
  localparam int RCP_OVR_EN     = 5;
  localparam int RCP_HCS_EN     = 6;
  localparam int RCP_DELIN_EN   = 7;
  localparam logic [7:0] RCP_EVT_RESET = 8'h00;
  localparam logic [7:0] RCP_EVT_EMASK = 8'he0;
  localparam logic [7:0] RCP_EVT_FMASK = 8'h1e;
  localparam logic [7:0] RCP_MATCH_RESET = 8'h00;
  // cell format and delineation thresholds
  localparam logic [5:0] RCP_HCS_IDX   = 6'h04;
  localparam logic [5:0] RCP_HDR_BYTES = 6'h05;
  localparam logic [5:0] RCP_CELL_LAST = 6'h34;
  localparam logic [2:0] RCP_ALPHA     = 3'h7;
  localparam logic [2:0] RCP_DELTA     = 3'h6;
  localparam logic [7:0] RCP_COSET     = 8'h55;
  localparam logic [7:0] RCP_CRC_POLY  = 8'h07;
  localparam int RCP_MEM_WORDS = 256;

  typedef enum logic [1:0] {
    RCP_HUNT    = 2'h0,
    RCP_PRESYNC = 2'h1,
    RCP_SYNC    = 2'h2
  } rcp_delin_type;

  typedef enum logic {
    RCP_CORR = 1'h0,
    RCP_DET  = 1'h1
  } rcp_check_type;

  // crc-8 of four header octets, msb first
  function automatic logic [7:0] rcp_crc8(input logic [31:0] hdr);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ hdr[i]) ? RCP_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // single-bit error pattern for a syndrome, zero when none fits
  function automatic logic [39:0] rcp_err_mask(input logic [7:0] syn);
    logic [39:0] v;
    logic [39:0] m;
    m = 40'h0;
    for (int i = 0; i < 40; i++) begin
      v = 40'h1 << i;
      if ((rcp_crc8(v[39:8]) ^ v[7:0]) == syn) begin
        m = v;
      end
    end
    return m;
  endfunction

  // self-synchronous x^43+1 descrambler, one octet msb first
  function automatic logic [50:0] rcp_descramble(input logic [42:0] st, input logic [7:0] din);
    logic [42:0] s;
    logic [7:0]  d;
    s = st;
    d = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      d[i] = din[i] ^ s[42];
      s = {s[41:0], din[i]};
    end
    return {s, d};
  endfunction
endpackage

// [testbench/rcp_cell_reader.sv]
// cell reader model standing for the atm layer side of the receive fifo
`timescale 1ns/1ns
`default_nettype none
module rcp_cell_reader (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // bench controls: stop reading, read every other cycle
  input  wire logic       hold,
  input  wire logic       slow,
  // fifo read side
  input  wire logic       cell_available,
  input  wire logic [7:0] data_out,
  input  wire logic       parity_out,
  input  wire logic       start_of_cell,
  input  wire logic       data_valid,
  output logic            read_enable,
  // last cell seen, parity above data
  output logic      [8:0] octet [53],
  output int              cells
);
  int   taken;
  int   idx;
  logic tick;
  // pull whole cells, one idle cycle after each 53rd read
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_enable <= 1'b0;
      taken       <= 0;
      tick        <= 1'b0;
    end else begin
      tick <= ~tick;
      if (read_enable && cell_available) begin
        taken <= (taken == 52) ? 0 : taken + 1;
      end
      read_enable <= cell_available && !hold && !(slow && tick) && !(read_enable && taken == 52);
    end
  end
  // collect the octets of the cell being delivered
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      idx   <= 0;
      cells <= 0;
    end else if (data_valid) begin
      octet[start_of_cell ? 0 : idx] <= {parity_out, data_out};
      idx <= start_of_cell ? 1 : idx + 1;
      if (!start_of_cell && idx == 52) begin
        cells <= cells + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/rcp_receive_cell_processor_tb.sv]
// self-checking bench of the receive cell processor
`timescale 1ns/1ns
`default_nettype none
module rcp_receive_cell_processor_tb;
  import rcp_pkg::*;
  localparam logic [31:0] HDR = 32'h12345670;
  // stimulus
  logic        ref_clk     = 1'b0;
  logic        reset_n     = 1'b0;
  logic [7:0]  reg_addr    = 8'h00;
  logic [7:0]  reg_wdata   = 8'h00;
  logic        reg_write   = 1'b0;
  logic        reg_read    = 1'b0;
  logic [7:0]  line_data   = 8'h00;
  logic        line_valid  = 1'b0;
  logic        hold        = 1'b0;
  logic        slow        = 1'b0;
  logic        ptype       = 1'b0;
  // observed
  logic [7:0]  reg_rdata;
  logic [7:0]  dout;
  logic        rd_en, avail, par, soc, dv, irq;
  logic [8:0]  octet [53];
  int          cells;
  int          miscompares = 0;
  int          comparisons = 0;
  // rows: address, write data, read-back value
  logic [23:0] rows [7]    = '{24'h507efe, 24'h51ffe0, 24'h52a5a5, 24'h535a5a, 24'h60ff00, 24'h500181, 24'h510000};

  // free-running clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  rcp_receive_cell_processor uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .line_data(line_data),
    .line_valid(line_valid), .receive_read_enable(rd_en), .receive_cell_available(avail),
    .receive_data_out(dout), .receive_parity_out(par), .receive_start_of_cell(soc),
    .receive_data_valid(dv), .receive_irq(irq)
  );
  rcp_cell_reader reader (
    .ref_clk(ref_clk), .reset_n(reset_n), .hold(hold), .slow(slow), .cell_available(avail),
    .data_out(dout), .parity_out(par), .start_of_cell(soc), .data_valid(dv),
    .read_enable(rd_en), .octet(octet), .cells(cells)
  );

  // compare and count
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // reset held for 8 cycles
  task automatic rst();
    reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
  endtask

  // register write, one strobe cycle then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  // register read, data compared under a mask in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    check($sformatf("reg %h", a), {1'b0, reg_rdata & m}, {1'b0, e});
    @(posedge ref_clk);
  endtask

  // bounded wait for the request level
  task automatic wirq(input logic e);
    @(negedge ref_clk);
    for (int i = 0; i < 20 && irq !== e; i++) begin
      @(negedge ref_clk);
    end
    check("irq", {8'h00, irq}, {8'h00, e});
    if (irq !== e) complete_run();
    @(posedge ref_clk);
  endtask

  // header check octet, msb first over four header octets
  function automatic logic [7:0] hec(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // one cell, optional bit flips in octet 0, optional coset, payload all ones
  task automatic send_cell(input logic [31:0] h, input logic [7:0] f, input logic cs);
    logic [7:0] b;
    for (int i = 0; i < 53; i++) begin
      b = (i < 4) ? h[31 - 8 * i -: 8] : (i == 4) ? hec(h) ^ (cs ? 8'h55 : 8'h00) : 8'hff;
      line_data  <= (i == 0) ? b ^ f : b;
      line_valid <= 1'b1;
      @(posedge ref_clk);
    end
    line_valid <= 1'b0;
    @(posedge ref_clk);
  endtask

  // wait for k more delivered cells; k of zero watches for strays
  task automatic settle(input int n0, input int k);
    for (int i = 0; i < 600 && !(k > 0 && cells - n0 >= k); i++) begin
      @(posedge ref_clk);
    end
    check("cells", 9'(cells - n0), 9'(k));
    if (cells - n0 < k) complete_run();
  endtask

  // send a cell, expect k deliveries and compare header, check octet, payload, parity
  task automatic xcell(input logic [31:0] h, input logic [7:0] f, input logic cs, input int k,
                       input logic [31:0] eh, input logic [7:0] ep);
    int         n0;
    logic [7:0] e;
    n0 = cells;
    send_cell(h, f, cs);
    settle(n0, k);
    for (int j = 0; j < 53 && k > 0; j++) begin
      e = (j < 4) ? eh[31 - 8 * j -: 8] : (j == 4) ? hec(h) ^ (cs ? 8'h55 : 8'h00) : ep;
      check("octet", octet[j], {^e ^ ~ptype, e});
    end
    $display("cell %h flip %h done", h, f);
  endtask

  // main sequence
  initial begin
    int n0;
    rst();
    for (int r = 0; r < 7; r++) begin
      wr(rows[r][23:16], rows[r][15:8]);
      rd(rows[r][23:16], rows[r][7:0], 8'hff);
    end
    $display("register rows done");
    // second reset in mid-run, then reset values
    rst();
    rd(8'h50, 8'h84, 8'hff);
    rd(8'h51, 8'h00, 8'hff);
    rd(8'h52, 8'h00, 8'hff);
    rd(8'h53, 8'h00, 8'hff);
    // idle cells bring sync and are all filtered
    wr(8'h50, 8'h06);
    wr(8'h51, 8'h80);
    n0 = cells;
    repeat (9) send_cell(32'h0, 8'h00, 1'b1);
    settle(n0, 0);
    rd(8'h50, 8'h06, 8'hff);
    wirq(1'b1);
    rd(8'h51, 8'h90, 8'hff);
    rd(8'h51, 8'h80, 8'hff);
    wirq(1'b0);
    $display("sync done");
    // both parity senses, slow reader on the second
    xcell(HDR, 8'h00, 1'b1, 1, HDR, 8'hff);
    wr(8'h50, 8'h46);
    ptype = 1'b1;
    slow <= 1'b1;
    xcell(HDR, 8'h00, 1'b1, 1, HDR, 8'hff);
    slow <= 1'b0;
    // masked pattern filter and filter pass
    wr(8'h52, 8'h01);
    wr(8'h53, 8'h01);
    xcell(32'h1, 8'h00, 1'b1, 0, 32'h1, 8'hff);
    xcell(32'h0, 8'h00, 1'b1, 1, 32'h0, 8'hff);
    wr(8'h50, 8'h66);
    xcell(32'h1, 8'h00, 1'b1, 1, 32'h1, 8'hff);
    wr(8'h53, 8'h00);
    // descrambler fed with ones yields zero payload
    wr(8'h50, 8'h44);
    n0 = cells;
    send_cell(HDR, 8'h00, 1'b1);
    settle(n0, 1);
    xcell(HDR, 8'h00, 1'b1, 1, HDR, 8'h00);
    // header errors with all enables off
    wr(8'h50, 8'h46);
    wr(8'h51, 8'h00);
    xcell(HDR, 8'h01, 1'b1, 1, HDR, 8'hff);
    xcell(HDR, 8'h00, 1'b1, 1, HDR, 8'hff);
    wr(8'h50, 8'h56);
    xcell(HDR, 8'h01, 1'b1, 0, HDR, 8'hff);
    xcell(HDR, 8'h00, 1'b1, 1, HDR, 8'hff);
    wr(8'h50, 8'h5e);
    xcell(HDR, 8'h01, 1'b1, 1, HDR ^ 32'h01000000, 8'hff);
    wr(8'h50, 8'h4e);
    repeat (2) xcell(HDR, 8'h01, 1'b1, 1, HDR, 8'hff);
    wirq(1'b0);
    wr(8'h51, 8'h40);
    wirq(1'b1);
    rd(8'h51, 8'h4c, 8'hff);
    rd(8'h51, 8'h40, 8'hff);
    // overrun with the reader stalled
    wr(8'h50, 8'h46);
    wr(8'h51, 8'h20);
    hold <= 1'b1;
    n0 = cells;
    repeat (5) send_cell(HDR, 8'h00, 1'b1);
    wirq(1'b1);
    rd(8'h51, 8'h22, 8'hff);
    hold <= 1'b0;
    settle(n0, 4);
    // fifo clear discards a stored cell and later writes
    hold <= 1'b1;
    send_cell(HDR, 8'h00, 1'b1);
    wr(8'h50, 8'h47);
    @(negedge ref_clk);
    check("cell available", {8'h00, avail}, 9'h000);
    @(posedge ref_clk);
    hold <= 1'b0;
    xcell(HDR, 8'h00, 1'b1, 0, HDR, 8'hff);
    wr(8'h50, 8'h46);
    xcell(HDR, 8'h00, 1'b1, 1, HDR, 8'hff);
    // coset off loses sync, then cells dropped while hunting
    wr(8'h51, 8'h00);
    wr(8'h50, 8'h42);
    repeat (8) send_cell(HDR, 8'h00, 1'b1);
    wirq(1'b0);
    rd(8'h50, 8'hc2, 8'hff);
    wr(8'h51, 8'h80);
    wirq(1'b1);
    rd(8'h51, 8'h10, 8'h10);
    xcell(HDR, 8'h00, 1'b0, 0, HDR, 8'hff);
    $display("hunt done");
    complete_run();
  end
endmodule
`default_nettype wire
